// File: src/rtc_defs.svh
// offsets, field positions and timing counts of the timer/alarm unit
// assumes a 10 MHz pclk and 32-bit APB data
//
// Overview of operation
// - with missing-clock enable set, flag fail if oscillator idles over 100 us
// - missing-clock timeout is offered as an output for irq, wake or reset
// - crystal amplitude detector readable as crystal valid, bit 4 of osc control
// - crystal valid is not trustworthy for 2 ms after oscillator power-up
// - 32-bit timer counts each oscillator cycle while run control is 1
// - timer wraps past maximum to zero and keeps counting
// - auto-reset clears timer one oscillator cycle after alarm match
// - writing alarm-flag bit sets auto-reset only, never the alarm flag
// - load and capture work while the timer runs
// - load strobe copies holding value into timer, then clears itself
// - capture strobe copies timer into holding value, then clears itself
// - alarm event raised only on exact equality of timer and match
// - alarm event is offered as an output for reset, wake or irq
// - clearing alarm enable clears the alarm event flag
// - re-enabling alarm with same match gives next alarm 2^32 cycles later
// - alarm event flag lasts at most one oscillator cycle
// - reading alarm-flag bit returns event flag, not auto-reset setting
// - oscillator fail flag set by hardware, stays until software clears
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH

`define RTC_CTRL_OFS     8'h00
`define RTC_OSC_OFS      8'h04
`define RTC_HOLD_OFS     8'h08
`define RTC_MATCH_OFS    8'h0c

`define CTL_MCD_BIT      6
`define CTL_FAIL_BIT     5
`define CTL_RUN_BIT      4
`define CTL_AEN_BIT      3
`define CTL_ALARM_FLAG_AUTORESET_BIT_BIT     2
`define CTL_LOAD_BIT     1
`define CTL_CAP_BIT      0
`define OSC_VALID_BIT    4

`define RTC_RESET_WORD   32'h0000_0000

`define CLK_PERIOD_NS    100
`define MISS_TIME_NS     100000
`define MISS_CYCLES      ((`MISS_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BLANK_TIME_NS    2000000
`define BLANK_CYCLES     ((`BLANK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: src/rtc_pkg.sv
// types shared by the timer/alarm unit and its oscillator monitor
// assumes rtc_defs.svh for all numeric constants
package rtc_pkg;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef enum logic [2:0] {
      SEL_CTRL,
      SEL_OSC,
      SEL_HOLD,
      SEL_MATCH,
      SEL_NONE
   } reg_sel_t;

   typedef struct packed {
      logic        osc_s1;
      logic        osc_s2;
      logic        osc_prev;
      logic [10:0] idle_cnt;
      logic        fired;
      logic        tick;
      logic        timeout;
   } mon_state_t;

   typedef struct packed {
      logic [31:0] timer;
      logic [31:0] alarm_match;
      logic [31:0] hold;
      logic        mcd_en;
      logic        fail;
      logic        run;
      logic        aen;
      logic        autoreset;
      logic        load;
      logic        capture;
      logic        alarm;
      logic        xv_s1;
      logic        xv_s2;
      logic        on_s1;
      logic        on_s2;
      logic        on_prev;
      logic [15:0] blank_cnt;
      logic [31:0] rdata;
      logic        slverr;
   } rtc_state_t;

endpackage

// File: src/rtc_osc_monitor.sv
// oscillator pin synchroniser, tick generator and missing-clock timer
// assumes osc_pin is asynchronous to pclk and much slower than it
`timescale 1ns/1ps
`include "rtc_defs.svh"
module rtc_osc_monitor (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic osc_pin,
   input  wire logic detect_en,
   output logic      osc_tick,
   output logic      timeout
);
   import rtc_pkg::*;

   localparam logic [10:0] MISS_LIMIT = 11'(`MISS_CYCLES);

   mon_state_t s;
   mon_state_t next_s;

   always_comb begin
      next_s = s;
      next_s.osc_s1 = osc_pin;
      next_s.osc_s2 = s.osc_s1;
      next_s.osc_prev = s.osc_s2;
      next_s.tick = s.osc_s2 & ~s.osc_prev;
      next_s.timeout = 1'b0;
      // any edge restarts the idle count and re-arms the one-shot
      if (s.osc_s2 != s.osc_prev || !detect_en) begin
         next_s.idle_cnt = 11'h000;
         next_s.fired = 1'b0;
      end else if (!s.fired) begin
         if (s.idle_cnt >= MISS_LIMIT) begin
            next_s.timeout = 1'b1;
            next_s.fired = 1'b1;
         end else begin
            next_s.idle_cnt = s.idle_cnt + 11'h001;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign osc_tick = s.tick;
   assign timeout = s.timeout;

endmodule

// File: src/rtc_timer_alarm.sv
// low-speed timer with load/capture holding word, equality alarm,
// missing-clock detector and crystal valid flag, behind an APB slave
// assumes the oscillator pins are asynchronous; one pclk domain only
`timescale 1ns/1ps
`include "rtc_defs.svh"
module rtc_timer_alarm #(
   parameter int BLANK_CYCLES = `BLANK_CYCLES
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire rtc_pkg::apb_req_t apb_req,
   output logic [31:0]           prdata,
   output logic                  pready,
   output logic                  pslverr,
   input  wire logic             osc_pin,
   input  wire logic             osc_enabled,
   input  wire logic             crystal_amp_ok,
   output logic                  alarm_event,
   output logic                  oscillator_fail_flag,
   output logic                  missing_clock_timeout
);
   import rtc_pkg::*;

   localparam logic [15:0] BLANK_LOAD = 16'(BLANK_CYCLES);

   ////////////////////////////////////////////////////////////////////
   // address decode

   function automatic reg_sel_t decode(input logic [7:0] addr);
      reg_sel_t sel;
      if (addr == `RTC_CTRL_OFS) begin
         sel = SEL_CTRL;
      end else if (addr == `RTC_OSC_OFS) begin
         sel = SEL_OSC;
      end else if (addr == `RTC_HOLD_OFS) begin
         sel = SEL_HOLD;
      end else if (addr == `RTC_MATCH_OFS) begin
         sel = SEL_MATCH;
      end else begin
         sel = SEL_NONE;
      end
      return sel;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // oscillator monitor

   rtc_state_t s;
   rtc_state_t next_s;
   logic       osc_tick;
   logic       miss_pulse;

   rtc_osc_monitor u_mon (
      .pclk      (pclk),
      .presetn   (presetn),
      .osc_pin   (osc_pin),
      .detect_en (s.mcd_en),
      .osc_tick  (osc_tick),
      .timeout   (miss_pulse)
   );

   ////////////////////////////////////////////////////////////////////
   // next state

   logic        setup;
   logic        wr;
   reg_sel_t    sel;
   logic [31:0] t;
   logic [31:0] rd;
   logic        xv_shown;

   always_comb begin
      next_s = s;
      setup = apb_req.psel & ~apb_req.penable;
      wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
      sel = decode(apb_req.paddr);
      t = s.timer;
      rd = 32'h0000_0000;

      // level synchronisers
      next_s.xv_s1 = crystal_amp_ok;
      next_s.xv_s2 = s.xv_s1;
      next_s.on_s1 = osc_enabled;
      next_s.on_s2 = s.on_s1;
      next_s.on_prev = s.on_s2;

      // blanking window after oscillator power-up
      if (s.on_s2 && !s.on_prev) begin
         next_s.blank_cnt = BLANK_LOAD;
      end else if (!s.on_s2) begin
         next_s.blank_cnt = BLANK_LOAD;
      end else if (s.blank_cnt != 16'h0000) begin
         next_s.blank_cnt = s.blank_cnt - 16'h0001;
      end
      xv_shown = s.xv_s2 & (s.blank_cnt == 16'h0000);

      // register writes
      if (wr) begin
         if (sel == SEL_CTRL) begin
            next_s.mcd_en = apb_req.pwdata[`CTL_MCD_BIT];
            next_s.run = apb_req.pwdata[`CTL_RUN_BIT];
            next_s.aen = apb_req.pwdata[`CTL_AEN_BIT];
            next_s.autoreset = apb_req.pwdata[`CTL_ALARM_FLAG_AUTORESET_BIT_BIT];
            if (!apb_req.pwdata[`CTL_AEN_BIT]) begin
               next_s.alarm = 1'b0;
            end
            if (!apb_req.pwdata[`CTL_FAIL_BIT]) begin
               next_s.fail = 1'b0;
            end
            if (apb_req.pwdata[`CTL_LOAD_BIT]) begin
               next_s.load = 1'b1;
            end
            if (apb_req.pwdata[`CTL_CAP_BIT]) begin
               next_s.capture = 1'b1;
            end
         end else if (sel == SEL_HOLD) begin
            next_s.hold = apb_req.pwdata;
         end else if (sel == SEL_MATCH) begin
            next_s.alarm_match = apb_req.pwdata;
         end
      end

      // hardware set of fail wins over a clearing write
      if (miss_pulse) begin
         next_s.fail = 1'b1;
      end

      // timer work happens only on oscillator ticks
      if (osc_tick) begin
         if (s.load) begin
            t = s.hold;
            next_s.load = 1'b0;
         end else if (s.alarm && s.autoreset) begin
            t = 32'h0000_0000;
         end else if (s.run) begin
            t = s.timer + 32'h0000_0001;
         end
         if (s.capture) begin
            next_s.hold = s.timer;
            next_s.capture = 1'b0;
         end
         next_s.timer = t;
         // flag raised on arrival at match, dropped at the next tick
         next_s.alarm = next_s.aen && (t == s.alarm_match)
                        && (t != s.timer);
      end

      // read data captured in the setup phase
      if (sel == SEL_CTRL) begin
         rd[`CTL_MCD_BIT] = s.mcd_en;
         rd[`CTL_FAIL_BIT] = s.fail;
         rd[`CTL_RUN_BIT] = s.run;
         rd[`CTL_AEN_BIT] = s.aen;
         rd[`CTL_ALARM_FLAG_AUTORESET_BIT_BIT] = s.alarm;
         rd[`CTL_LOAD_BIT] = s.load;
         rd[`CTL_CAP_BIT] = s.capture;
      end else if (sel == SEL_OSC) begin
         rd[`OSC_VALID_BIT] = xv_shown;
      end else if (sel == SEL_HOLD) begin
         rd = s.hold;
      end else if (sel == SEL_MATCH) begin
         rd = s.alarm_match;
      end
      if (setup) begin
         next_s.rdata = apb_req.pwrite ? 32'h0000_0000 : rd;
         next_s.slverr = (sel == SEL_NONE);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         s.blank_cnt <= 16'hffff;
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs

   assign pready = apb_req.psel & apb_req.penable;
   assign prdata = s.rdata;
   assign pslverr = apb_req.psel & apb_req.penable & s.slverr;
   assign alarm_event = s.alarm;
   assign oscillator_fail_flag = s.fail;
   assign missing_clock_timeout = miss_pulse;

endmodule

// File: test/rtc_timer_alarm_monitor.sv
// port assertions for the timer/alarm unit
// assumes osc_pin changes only on pclk edges in simulation
`timescale 1ns/1ps
`include "rtc_defs.svh"
module rtc_ta_checker #(
   parameter int BLANK_CYCLES = 20
) (
   input wire logic              pclk,
   input wire logic              presetn,
   input wire rtc_pkg::apb_req_t apb_req,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic              osc_pin,
   input wire logic              osc_enabled,
   input wire logic              crystal_amp_ok,
   input wire logic              alarm_event,
   input wire logic              oscillator_fail_flag,
   input wire logic              missing_clock_timeout
);
   import rtc_pkg::*;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic        last;
   logic [10:0] idle;
   logic [3:0]  srise;
   logic [15:0] bcnt;
   wire acc     = apb_req.psel && apb_req.penable;
   wire wr_ctrl = acc && apb_req.pwrite && apb_req.paddr == `RTC_CTRL_OFS;
   wire rd_osc  = acc && !apb_req.pwrite && apb_req.paddr == `RTC_OSC_OFS;
   wire bad_adr = apb_req.paddr > `RTC_MATCH_OFS || apb_req.paddr[1:0] != 2'b00;
   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last <= 1'b0;
         idle <= 11'h000;
         srise <= 4'hf;
         bcnt <= 16'h0000;
      end else begin
         last <= osc_pin;
         idle <= (osc_pin != last) ? 11'h000 : idle + {10'h000, idle != 11'h7ff};
         srise <= (osc_pin && !last) ? 4'h0 : srise + {3'h0, srise != 4'hf};
         bcnt <= !osc_enabled ? 16'h0000 : bcnt + {15'h0000, bcnt != 16'hffff};
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   sequence s_alarm_held;
      $rose(osc_pin) ##0 alarm_event;
   endsequence
   property p_ready;
      acc |-> pready && pslverr == bad_adr;
   endproperty
   property p_fail_sticky;
      oscillator_fail_flag && !(wr_ctrl && !apb_req.pwdata[`CTL_FAIL_BIT])
         |=> oscillator_fail_flag;
   endproperty
   property p_timeout_sets;
      missing_clock_timeout |-> ##[0:2] oscillator_fail_flag;
   endproperty
   property p_timeout_idle;
      missing_clock_timeout |-> idle >= 11'd995;
   endproperty
   property p_alarm_short;
      s_alarm_held |-> ##[1:6] !alarm_event;
   endproperty
   property p_aen_clear;
      wr_ctrl && !apb_req.pwdata[`CTL_AEN_BIT] |=> !alarm_event;
   endproperty
   property p_alarm_tick;
      $rose(alarm_event) |-> srise <= 4'd8;
   endproperty
   property p_blank;
      rd_osc && bcnt < BLANK_CYCLES |-> !prdata[`OSC_VALID_BIT];
   endproperty
   a_ready:       assert property (p_ready) else $error("apb answer wrong");
   a_fail_sticky: assert property (p_fail_sticky) else $error("fail flag lost");
   a_timeout_sets: assert property (p_timeout_sets) else $error("fail not set");
   a_timeout_idle: assert property (p_timeout_idle) else $error("early timeout");
   a_alarm_short: assert property (p_alarm_short) else $error("alarm too long");
   a_aen_clear:   assert property (p_aen_clear) else $error("alarm not cleared");
   a_alarm_tick:  assert property (p_alarm_tick) else $error("alarm off tick");
   a_blank:       assert property (p_blank) else $error("valid during blanking");
endmodule
bind rtc_timer_alarm rtc_ta_checker #(.BLANK_CYCLES(BLANK_CYCLES)) i_rtc_ta_checker (
   .pclk, .presetn, .apb_req, .prdata, .pready, .pslverr, .osc_pin, .osc_enabled,
   .crystal_amp_ok, .alarm_event, .oscillator_fail_flag, .missing_clock_timeout);

// File: test/rtc_osc_model.sv
// low-speed oscillator model, toggles every HALF pclk cycles
// assumes go from the bench; stops only in the low half
`timescale 1ns/1ps
module rtc_osc_model #(
   parameter int HALF = 20
) (
   input  wire logic pclk,
   input  wire logic go,
   output logic      osc_pin
);
   logic [7:0] cnt = 8'h00;
   initial osc_pin = 1'b0;
   always @(posedge pclk) begin
      if (cnt == 8'(HALF - 1)) begin
         cnt <= 8'h00;
         if (go || osc_pin) osc_pin <= !osc_pin;
      end else cnt <= cnt + 8'h01;
   end
endmodule

// File: test/tb.sv
// self-checking bench for the timer/alarm unit over apb
// assumes rtc_osc_model as oscillator and the bound checker
`timescale 1ns/1ps
`include "rtc_defs.svh"
module tb;
   import rtc_pkg::*;
   localparam int BLANK = 20;
   logic        pclk, presetn, go, osc_pin, osc_enabled, crystal_amp_ok;
   logic        pready, pslverr, alarm_event, oscillator_fail_flag, missing_clock_timeout;
   logic [31:0] prdata, q;
   apb_req_t    req;
   int          fail_count, checks_done, edges, e0, n;
   rtc_timer_alarm #(.BLANK_CYCLES(BLANK)) i_rtc_timer_alarm (.pclk(pclk), .presetn(presetn),
      .apb_req(req), .prdata(prdata), .pready(pready), .pslverr(pslverr), .osc_pin(osc_pin),
      .osc_enabled(osc_enabled), .crystal_amp_ok(crystal_amp_ok), .alarm_event(alarm_event),
      .oscillator_fail_flag(oscillator_fail_flag), .missing_clock_timeout(missing_clock_timeout));
   rtc_osc_model i_rtc_osc_model (.pclk(pclk), .go(go), .osc_pin(osc_pin));
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   always @(posedge osc_pin) edges++;
   ////////////////////////////////////////////////////////////////////////////////
   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      req.penable <= 1'b1;
      // pready going high ends this wait; the watchdog ends a hung access
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask
   task poll(input int b);
      repeat (100) begin
         apb(1'b0, `RTC_CTRL_OFS, 32'h0000_0000);
         if (q[b] === 1'b0) begin
            break;
         end
      end
      chk("strobe", 32'(q[b]), 32'h0000_0000);
   endtask
   task wait_alarm;
      n = 0;
      while (alarm_event !== 1'b1 && n < 2000) begin
         @(posedge pclk);
         n++;
      end
      chk("alarm seen", {31'h0, alarm_event}, 32'h0000_0001);
   endtask
   task idle_osc;
      go <= 1'b0;
      repeat (60) @(posedge pclk);
   endtask
   task final_report;
      $display("errors %0d checks %0d", fail_count, checks_done);
      if (fail_count == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge pclk);
      fail_count++;
      final_report;
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      presetn = 1'b0;
      go = 1'b0;
      osc_enabled = 1'b0;
      crystal_amp_ok = 1'b0;
      req = '0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      for (int a = 0; a < 20; a += 4) begin
         apb(1'b0, 8'(a), 32'h0000_0000);
         chk("reset", q, `RTC_RESET_WORD);
      end
      osc_enabled <= 1'b1;
      crystal_amp_ok <= 1'b1;
      apb(1'b0, `RTC_OSC_OFS, 32'h0000_0000);
      chk("blank", q, 32'h0000_0000);
      repeat (BLANK + 10) @(posedge pclk);
      apb(1'b0, `RTC_OSC_OFS, 32'h0000_0000);
      chk("valid", q, 32'h0000_0010);
      // load while running, count across the wrap
      apb(1'b1, `RTC_HOLD_OFS, 32'hffff_fffd);
      apb(1'b1, `RTC_CTRL_OFS, 32'h0000_0012);
      e0 = edges;
      go <= 1'b1;
      poll(`CTL_LOAD_BIT);
      repeat (200) @(posedge pclk);
      idle_osc;
      e0 = edges - e0;
      apb(1'b1, `RTC_CTRL_OFS, 32'h0000_0001);
      go <= 1'b1;
      poll(`CTL_CAP_BIT);
      idle_osc;
      apb(1'b0, `RTC_HOLD_OFS, 32'h0000_0000);
      chk("timer", q, 32'hffff_fffc + 32'(e0));
      // alarm with auto-reset
      apb(1'b1, `RTC_CTRL_OFS, 32'h0000_0000);
      apb(1'b1, `RTC_MATCH_OFS, 32'h0000_0010);
      apb(1'b1, `RTC_HOLD_OFS, 32'h0000_000d);
      apb(1'b1, `RTC_CTRL_OFS, 32'h0000_001e);
      apb(1'b0, `RTC_CTRL_OFS, 32'h0000_0000);
      chk("ctrl", q, 32'h0000_001a);
      e0 = edges;
      go <= 1'b1;
      wait_alarm;
      chk("alarm edges", 32'(edges - e0), 32'h0000_0004);
      apb(1'b0, `RTC_CTRL_OFS, 32'h0000_0000);
      chk("flag", q & 32'h0000_0004, 32'h0000_0004);
      e0 = edges;
      repeat (50) @(posedge pclk);
      idle_osc;
      e0 = edges - e0;
      apb(1'b1, `RTC_CTRL_OFS, 32'h0000_0011);
      go <= 1'b1;
      poll(`CTL_CAP_BIT);
      idle_osc;
      apb(1'b0, `RTC_HOLD_OFS, 32'h0000_0000);
      chk("auto reset", q, 32'(e0 - 1));
      // oscillator stopped with detector on
      apb(1'b1, `RTC_CTRL_OFS, 32'h0000_0040);
      repeat (950) @(posedge pclk);
      chk("no early fail", {31'h0, oscillator_fail_flag}, 32'h0000_0000);
      repeat (150) @(posedge pclk);
      chk("fail", {31'h0, oscillator_fail_flag}, 32'h0000_0001);
      apb(1'b1, `RTC_CTRL_OFS, 32'h0000_0060);
      apb(1'b0, `RTC_CTRL_OFS, 32'h0000_0000);
      chk("sticky", q, 32'h0000_0060);
      apb(1'b1, `RTC_CTRL_OFS, 32'h0000_0000);
      apb(1'b0, `RTC_CTRL_OFS, 32'h0000_0000);
      chk("cleared", q, 32'h0000_0000);
      // perpetual timebase: match advanced by modular addition across the wrap
      apb(1'b1, `RTC_HOLD_OFS, 32'hffff_fffe);
      apb(1'b1, `RTC_MATCH_OFS, 32'hffff_fffe + 32'h0000_0003);
      apb(1'b1, `RTC_CTRL_OFS, 32'h0000_001a);
      e0 = edges;
      go <= 1'b1;
      wait_alarm;
      chk("wrap alarm", 32'(edges - e0), 32'h0000_0004);
      apb(1'b1, `RTC_CTRL_OFS, 32'h0000_0010);
      apb(1'b0, `RTC_CTRL_OFS, 32'h0000_0000);
      chk("aen clear", q, 32'h0000_0010);
      idle_osc;
      osc_enabled <= 1'b0;
      final_report;
   end
endmodule
